// ===== logic/dual_wiper_two_wire_slave.sv
// Two-wire slave holding two wiper position registers
`default_nettype none
// Behaviour
// - One 8-bit position register per wiper, choosing one of 256 taps.
// - Code FFh is the high end, 00h the low end, monotonic between.
// - Both position registers start at 00h after power-up reset.
// - Select pins must equal the control byte's select bits to respond.
// - Device is slave only; the master makes clock, START and STOP.
// - Data changes while clock is high are bus conditions, not data.
// - Data falling with clock high is START; restart bit count.
// - Data rising with clock high is STOP; end transfer, go idle.
// - One clock pulse per bit; change data low, sample while high.
// - Eight-bit bytes plus a ninth acknowledge bit; master sets count.
// - Acknowledger holds data low through the acknowledge clock high.
// - After master not-acknowledge, slave releases data for STOP.
// - Write: control, command, data bytes; acks one data byte, two after the wiper 0 command.
// - Repeated START ends a transfer and expects a new control byte.
// - Direction bit 0 selects receive mode, 1 selects transmit mode.
// - Transmit shifts data on master clock; START and STOP still seen.
// - Control byte is code 0101, three select bits, direction bit.
// - Command byte writes wiper 0 (then 1), wiper 1, or both.
// - Read returns wiper 0 first, wiper 1 after a master ack.
// - Bytes go most significant bit first; the receiver acknowledges.
module dual_wiper_two_wire_slave
  import wiper_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic select_pin_bit0_in,
  input wire logic select_pin_bit1_in,
  input wire logic select_pin_bit2_in,
  output logic [7:0] wiper_out_zero_out,
  output logic [7:0] wiper_out_one_out
);
  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Control byte addresses this device
  function automatic logic ctrl_match(input logic [7:0] b,
                                      input logic [2:0] sel);
    ctrl_match = (b[7:CODE_LSB] == CTRL_CODE) &&
                 (b[CODE_LSB-1:SEL_LSB] == sel);
  endfunction

  // Command byte to its write target, none if unknown
  function automatic logic [1:0] cmd_target(input logic [7:0] b);
    cmd_target = TGT_NONE;
    if (b == CMD_WR_ZERO) begin
      cmd_target = TGT_ZERO;
    end else if (b == CMD_WR_ONE) begin
      cmd_target = TGT_ONE;
    end else if (b == CMD_WR_BOTH) begin
      cmd_target = TGT_BOTH;
    end
  endfunction

  // Which wiper a data byte lands in, given command and position
  function automatic logic [1:0] data_target(input logic [1:0] tgt,
                                             input logic [1:0] idx);
    data_target = TGT_NONE;
    if (idx == IDX_DATA0) begin
      data_target = tgt;
    end else if (idx == IDX_DATA1 && tgt == TGT_ZERO) begin
      data_target = TGT_ONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] idx;
    logic [1:0] tgt;
    logic rd;
    logic rd_sel;
    logic mack;
    logic oe;
    logic [7:0] w0;
    logic [7:0] w1;
  } core_t;
  core_t core_ff;
  core_t nxt_core;

  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_lvl;
  logic [PIN_COUNT-1:0] pins_prv;
  logic scl_lvl;
  logic sda_lvl;
  logic [2:0] sel_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic accept;
  logic load_tx;
  logic [1:0] data_tgt;
  logic [7:0] tx_byte;

  stream_if #(.W(FIFO_WIDTH)) fill_bus ();
  stream_if #(.W(FIFO_WIDTH)) drain_bus ();

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and line events

  // Bus lines and select straps all cross into the clock domain
  assign pins_raw = {select_pin_bit2_in, select_pin_bit1_in,
                     select_pin_bit0_in, sda_in, scl_in};

  line_sync #(.W(PIN_COUNT)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(pins_raw),
    .level_out(pins_lvl),
    .prev_out(pins_prv)
  );

  // Edges found on synced copies only
  assign scl_lvl = pins_lvl[0];
  assign sda_lvl = pins_lvl[1];
  assign sel_lvl = pins_lvl[4:2];
  assign scl_rise = scl_lvl && !pins_prv[0];
  assign scl_fall = !scl_lvl && pins_prv[0];
  // Data moving while clock stays high is a bus condition
  assign start_det = scl_lvl && pins_prv[0] &&
                     pins_prv[1] && !sda_lvl;
  assign stop_det = scl_lvl && pins_prv[0] &&
                    !pins_prv[1] && sda_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Byte decisions and write queue

  // Eighth bit sampled and its clock has fallen
  assign byte_done = (core_ff.st == ST_RECV) && scl_fall &&
                     (core_ff.cnt == BITS_PER_BYTE);
  assign data_tgt = data_target(core_ff.tgt, core_ff.idx);
  assign fill_bus.valid = byte_done && (data_tgt != TGT_NONE);
  assign fill_bus.data = {data_tgt, core_ff.sh};

  // A full queue makes the device refuse the byte with a nack
  always_comb begin
    if (core_ff.idx == IDX_CTRL) begin
      accept = ctrl_match(core_ff.sh, sel_lvl);
    end else if (core_ff.idx == IDX_CMD) begin
      accept = cmd_target(core_ff.sh) != TGT_NONE;
    end else begin
      accept = fill_bus.valid && fill_bus.ready;
    end
  end

  word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_queue (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .fill_in(fill_bus),
    .drain_out(drain_bus)
  );

  // Writes wait while a read is shifting out, so a read sees one value
  assign drain_bus.ready = (core_ff.st != ST_SEND) &&
                           (core_ff.st != ST_MACK);
  assign tx_byte = core_ff.rd_sel ? core_ff.w1 : core_ff.w0;

  ////////////////////////////////////////////////////////////////////////
  // Protocol engine

  // Next state: conditions first, then per-state bit handling
  always_comb begin
    nxt_core = core_ff;
    load_tx = 1'b0;
    if (drain_bus.valid && drain_bus.ready) begin
      if (drain_bus.data[TGT_ZERO_BIT]) begin
        nxt_core.w0 = drain_bus.data[7:0];
      end
      if (drain_bus.data[TGT_ONE_BIT]) begin
        nxt_core.w1 = drain_bus.data[7:0];
      end
    end
    if (start_det) begin
      // Also covers repeated START mid transfer
      nxt_core.st = ST_RECV;
      nxt_core.cnt = '0;
      nxt_core.idx = IDX_CTRL;
      nxt_core.tgt = TGT_NONE;
      nxt_core.rd = 1'b0;
      nxt_core.oe = 1'b0;
    end else if (stop_det) begin
      nxt_core.st = ST_IDLE;
      nxt_core.oe = 1'b0;
    end else begin
      unique case (core_ff.st)
        ST_IDLE: begin
          nxt_core.oe = 1'b0;
        end
        ST_RECV: begin
          if (scl_rise) begin
            nxt_core.sh = {core_ff.sh[6:0], sda_lvl};
            nxt_core.cnt = core_ff.cnt + 4'h1;
          end else if (byte_done) begin
            if (core_ff.idx == IDX_CTRL) begin
              nxt_core.rd = core_ff.sh[DIR_BIT];
              nxt_core.rd_sel = 1'b0;
            end
            if (core_ff.idx == IDX_CMD) begin
              nxt_core.tgt = cmd_target(core_ff.sh);
            end
            // Pull low right after the fall so it is stable while high
            nxt_core.st = accept ? ST_ACK : ST_IGNORE;
            nxt_core.oe = accept;
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            nxt_core.cnt = ACK_BIT;
          end else if (scl_fall && core_ff.cnt == ACK_BIT) begin
            nxt_core.oe = 1'b0;
            nxt_core.cnt = '0;
            if (core_ff.idx != IDX_DATA1) begin
              nxt_core.idx = core_ff.idx + 2'h1;
            end
            if (core_ff.rd) begin
              load_tx = 1'b1;
            end else if (core_ff.idx == IDX_DATA1) begin
              // No command takes a third data byte: refuse it by silence
              nxt_core.st = ST_IGNORE;
            end else begin
              nxt_core.st = ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            nxt_core.cnt = core_ff.cnt + 4'h1;
          end else if (scl_fall) begin
            if (core_ff.cnt == BITS_PER_BYTE) begin
              nxt_core.st = ST_MACK;
              nxt_core.oe = 1'b0;
            end else begin
              nxt_core.sh = {core_ff.sh[6:0], 1'b0};
              nxt_core.oe = !core_ff.sh[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nxt_core.cnt = ACK_BIT;
            nxt_core.mack = !sda_lvl;
          end else if (scl_fall && core_ff.cnt == ACK_BIT) begin
            if (core_ff.mack) begin
              load_tx = 1'b1;
            end else begin
              nxt_core.st = ST_IGNORE;
            end
          end
        end
        ST_IGNORE: begin
          nxt_core.oe = 1'b0;
        end
      endcase
    end
    // Open drain: a zero bit drives, a one bit releases
    if (load_tx) begin
      nxt_core.st = ST_SEND;
      nxt_core.sh = tx_byte;
      nxt_core.oe = !tx_byte[7];
      nxt_core.rd_sel = !core_ff.rd_sel;
      nxt_core.cnt = '0;
    end
  end

  // Volatile wipers return to the low end on reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      core_ff <= '{st: ST_IDLE, cnt: 4'h0, sh: 8'h00, idx: IDX_CTRL,
                   tgt: TGT_NONE, rd: 1'b0, rd_sel: 1'b0, mack: 1'b0,
                   oe: 1'b0, w0: WIPER_RESET, w1: WIPER_RESET};
    end else begin
      core_ff <= nxt_core;
    end
  end

  // Clock is never driven; data pin only pulls low
  assign sda_out = 1'b0;
  assign sda_oe_out = core_ff.oe;
  assign wiper_out_zero_out = core_ff.w0;
  assign wiper_out_one_out = core_ff.w1;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_ctrl_done;
    byte_done && core_ff.idx == IDX_CTRL;
  endsequence

  sequence s_read_begin;
    core_ff.st == ST_ACK && scl_fall && core_ff.cnt == ACK_BIT &&
    core_ff.rd && core_ff.idx == IDX_CTRL;
  endsequence

  sequence s_nack;
    core_ff.st == ST_MACK && scl_fall && core_ff.cnt == ACK_BIT &&
    !core_ff.mack;
  endsequence

  a_start_restart:
  assert property (start_det |=> core_ff.st == ST_RECV &&
                   core_ff.cnt == 4'h0 && !sda_oe_out)
  else $error("START did not restart reception");

  a_stop_idle:
  assert property (stop_det |=> core_ff.st == ST_IDLE && !sda_oe_out)
  else $error("STOP did not return to idle");

  a_ack_drive:
  assert property (core_ff.st == ST_ACK |-> sda_oe_out)
  else $error("data released during acknowledge");

  a_ignore_quiet:
  assert property (core_ff.st == ST_IGNORE |-> !sda_oe_out)
  else $error("data driven while ignoring");

  a_drive_after_fall:
  assert property ($changed(sda_oe_out) |->
                   $past(scl_fall) || $past(start_det) || $past(stop_det))
  else $error("data pin changed outside clock low");

  a_match_ack:
  assert property (s_ctrl_done ##0 ctrl_match(core_ff.sh, sel_lvl)
                   |=> core_ff.st == ST_ACK && sda_oe_out)
  else $error("matching control byte not acknowledged");

  a_mismatch_ignored:
  assert property (s_ctrl_done ##0 !ctrl_match(core_ff.sh, sel_lvl)
                   |=> core_ff.st == ST_IGNORE)
  else $error("foreign control byte not ignored");

  a_read_first_w0:
  assert property (s_read_begin |=> core_ff.st == ST_SEND &&
                   core_ff.sh == $past(core_ff.w0) &&
                   sda_oe_out == !$past(core_ff.w0[7]))
  else $error("read did not begin with wiper zero");

  a_nack_release:
  assert property (s_nack |=> core_ff.st == ST_IGNORE && !sda_oe_out)
  else $error("data not released after nack");

  a_wiper_reset:
  assert property (@(posedge clk_in) disable iff (1'b0)
                   $fell(reset_in) |-> wiper_out_zero_out == 8'h00 &&
                   wiper_out_one_out == 8'h00)
  else $error("wipers not at low end after reset");
endmodule
`default_nettype wire

// ===== logic/wiper_pkg.sv
// Shared constants and types of the dual wiper two-wire slave
`default_nettype none
package wiper_pkg;
  // Control byte layout: code, select bits, direction bit
  localparam logic [3:0] CTRL_CODE = 4'h5;
  localparam int CODE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int DIR_BIT = 0;

  // Command byte codes
  localparam logic [7:0] CMD_WR_ZERO = 8'hA9;
  localparam logic [7:0] CMD_WR_ONE = 8'hAA;
  localparam logic [7:0] CMD_WR_BOTH = 8'hAF;

  // Write targets, one bit per wiper
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_ZERO = 2'h1;
  localparam logic [1:0] TGT_ONE = 2'h2;
  localparam logic [1:0] TGT_BOTH = 2'h3;

  // Byte position within a transfer
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_DATA0 = 2'h2;
  localparam logic [1:0] IDX_DATA1 = 2'h3;

  // Bit counts and reset values
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [7:0] WIPER_RESET = 8'h00;

  // Write queue word: {target, data}
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int TGT_ZERO_BIT = 8;
  localparam int TGT_ONE_BIT = 9;
  localparam int PIN_COUNT = 5;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_ACK = 6'h04,
    ST_SEND = 6'h08,
    ST_MACK = 6'h10,
    ST_IGNORE = 6'h20
  } state_t;
endpackage
`default_nettype wire

// ===== logic/stream_if.sv
// Valid/ready word stream between the slave core and its write queue
`default_nettype none
interface stream_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/line_sync.sv
// Two-stage synchroniser with a third stage for edge detection
`default_nettype none
module line_sync #(parameter int W = 5) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] prev_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;
  sync_t sync_ff;
  sync_t nxt_sync;

  // Idle bus is high, so all stages reset high to avoid a false START
  always_comb begin
    nxt_sync.s1 = async_in;
    nxt_sync.s2 = sync_ff.s1;
    nxt_sync.s3 = sync_ff.s2;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_ff <= '1;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign level_out = sync_ff.s2;
  assign prev_out = sync_ff.s3;
endmodule
`default_nettype wire

// ===== logic/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  stream_if.snk fill_in,
  stream_if.src drain_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_t;
  fifo_t fifo_ff;
  fifo_t nxt_fifo;
  logic push;
  logic pop;

  assign fill_in.ready = fifo_ff.cnt != CW'(DEPTH);
  assign drain_out.valid = fifo_ff.cnt != '0;
  assign drain_out.data = fifo_ff.mem[fifo_ff.rp];
  assign push = fill_in.valid && fill_in.ready;
  assign pop = drain_out.valid && drain_out.ready;

  // Pointers wrap naturally; depth must be a power of two
  always_comb begin
    nxt_fifo = fifo_ff;
    if (push) begin
      nxt_fifo.mem[fifo_ff.wp] = fill_in.data;
      nxt_fifo.wp = fifo_ff.wp + PW'(1);
    end
    if (pop) begin
      nxt_fifo.rp = fifo_ff.rp + PW'(1);
    end
    if (push && !pop) begin
      nxt_fifo.cnt = fifo_ff.cnt + CW'(1);
    end else if (pop && !push) begin
      nxt_fifo.cnt = fifo_ff.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      fifo_ff <= '0;
    end else begin
      fifo_ff <= nxt_fifo;
    end
  end

  a_fifo_count_step:
  assert property (@(posedge clk_in) disable iff (reset_in)
    push && !pop |=> fifo_ff.cnt == $past(fifo_ff.cnt) + CW'(1))
  else $error("fifo count did not grow on push");
endmodule
`default_nettype wire

// ===== dv/bus_master.sv
// Behavioural two-wire bus master that drives the bus clock and data lines
`default_nettype none
module bus_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero: clock high, data released to its pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter of an 800 ns bus clock period
  task automatic q();
    repeat (2) @(posedge clk_in);
  endtask

  // One bit per pulse, data moved only while the clock is low
  task automatic put_bit(input logic b, output logic seen);
    q();
    sda_low_out <= ~b;
    q();
    scl_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    // Sample off the edge so the slave's updates have landed
    @(negedge clk_in) seen = sda_in;
    @(posedge clk_in) scl_out <= 1'b0;
  endtask

  // Data falls with clock high; also used as repeated start
  task automatic start_cond();
    q();
    sda_low_out <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    q();
    sda_low_out <= 1'b1;
    q();
    q();
    scl_out <= 1'b0;
  endtask

  // Data rises with clock high, leaving the bus idle
  task automatic stop_cond();
    q();
    sda_low_out <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    q();
    sda_low_out <= 1'b0;
    q();
    q();
  endtask

  // Eight bits MSB first, then a released ninth pulse for the slave ack
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // Reads eight bits, then acks or withholds the ack on pulse nine
  task automatic read_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(~mack, s);
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the dual wiper two-wire slave
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wiper_pkg::*;

  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] sel = 3'h0;
  int fails = 0;
  int comparisons = 0;
  wire logic scl;
  wire logic sda_low;
  wire logic sda_drv;
  wire logic sda_oe;
  wire logic [7:0] w0;
  wire logic [7:0] w1;
  // Open-drain data line with pull-up: low if either party pulls
  wire logic sda_line = ((sda_oe && !sda_drv) || sda_low) ? 1'b0 : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  always #50 clk_in = ~clk_in;

  dual_wiper_two_wire_slave dut (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_drv),
    .sda_oe_out(sda_oe),
    .select_pin_bit0_in(sel[0]),
    .select_pin_bit1_in(sel[1]),
    .select_pin_bit2_in(sel[2]),
    .wiper_out_zero_out(w0),
    .wiper_out_one_out(w1)
  );

  bus_master master (
    .clk_in(clk_in),
    .sda_in(sda_line),
    .scl_out(scl),
    .sda_low_out(sda_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Single compare point; four-state equality so unknowns never match
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wbyte(input logic [7:0] d, input logic exp_ack);
    logic ack;
    master.write_byte(d, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic rbyte(input logic mack, input logic [7:0] exp);
    logic [7:0] d;
    master.read_byte(mack, d);
    check(d, exp);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check(w0, WIPER_RESET);
    check(w1, WIPER_RESET);
    $display("Test reset values done");
    // Wiper 0 then wiper 1, surplus byte refused
    master.start_cond();
    wbyte(8'h50, 1'b1);
    wbyte(CMD_WR_ZERO, 1'b1);
    wbyte(8'h5A, 1'b1);
    wbyte(8'hC3, 1'b1);
    wbyte(8'h11, 1'b0);
    master.stop_cond();
    check(w0, 8'h5A);
    check(w1, 8'hC3);
    $display("Test write wiper zero done");
    // Read both, master nack on the last
    master.start_cond();
    wbyte(8'h51, 1'b1);
    rbyte(1'b1, 8'h5A);
    rbyte(1'b0, 8'hC3);
    // Give the slave time to react; a wrong reload would pull low here
    repeat (4) @(posedge clk_in);
    check({7'h00, sda_line}, 8'h01);
    master.stop_cond();
    $display("Test read done");
    // Wiper 1 only, top code
    master.start_cond();
    wbyte(8'h50, 1'b1);
    wbyte(CMD_WR_ONE, 1'b1);
    wbyte(8'hFF, 1'b1);
    master.stop_cond();
    check(w1, 8'hFF);
    check(w0, 8'h5A);
    $display("Test write wiper one done");
    // Select mismatch and wrong code are ignored
    @(posedge clk_in) sel <= 3'h5;
    master.start_cond();
    wbyte(8'h50, 1'b0);
    wbyte(CMD_WR_BOTH, 1'b0);
    wbyte(8'h00, 1'b0);
    master.stop_cond();
    master.start_cond();
    wbyte(8'h7A, 1'b0);
    master.stop_cond();
    check(w1, 8'hFF);
    master.start_cond();
    wbyte(8'h5A, 1'b1);
    wbyte(CMD_WR_BOTH, 1'b1);
    wbyte(8'h3C, 1'b1);
    master.stop_cond();
    check(w0, 8'h3C);
    check(w1, 8'h3C);
    $display("Test select and both done");
    // Repeated start before data; unknown command refused
    master.start_cond();
    wbyte(8'h5A, 1'b1);
    wbyte(CMD_WR_ONE, 1'b1);
    master.start_cond();
    wbyte(8'h5B, 1'b1);
    rbyte(1'b0, 8'h3C);
    master.start_cond();
    wbyte(8'h5A, 1'b1);
    wbyte(8'h00, 1'b0);
    master.stop_cond();
    check(w1, 8'h3C);
    $display("Test repeated start done");
    close_out();
  end
endmodule
`default_nettype wire
